//--- bench/ecsw_chk.sv
// Checker for the encoder word block, bound to its top module.
// Assumes only the top module's ports; one clock domain.
`timescale 1ns/1ps
module ecsw_chk #(
  parameter int POS_W = 32
) (
  input logic clk,
  input logic rst_n,
  input logic direct_access_en,
  input logic telegram_valid,
  input logic [15:0] encoder1_control_word,
  input logic enc1_cam1_level,
  input logic enc1_step,
  input logic enc1_dir,
  input logic enc1_fault,
  input logic [15:0] encoder1_status_word,
  input logic [15:0] encoder2_status_word,
  input logic [POS_W-1:0] encoder1_position_word_a,
  input logic [POS_W-1:0] encoder1_position_word_b,
  input logic enc1_power_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_cam_level;
    direct_access_en |=> encoder1_status_word[8] == $past(enc1_cam1_level);
  endproperty
  a_cam_level: assert property (p_cam_level) else $error("cam level bit wrong");

  property p_reserved;
    !(encoder1_status_word[10] || encoder1_status_word[12] || encoder2_status_word[10] || encoder2_status_word[12]);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");

  property p_no_access;
    !direct_access_en |=> encoder1_status_word == 16'h0000 && encoder2_status_word == 16'h0000;
  endproperty
  a_no_access: assert property (p_no_access) else $error("status without access");

  property p_power;
    direct_access_en && $past(direct_access_en) |-> enc1_power_en == !encoder1_status_word[14];
  endproperty
  a_power: assert property (p_power) else $error("supply does not follow park");

  property p_fault;
    direct_access_en && enc1_fault && !encoder1_status_word[14] ##1 direct_access_en && !encoder1_status_word[14]
      |-> encoder1_status_word[15];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shown");

  property p_fault_code;
    encoder1_status_word[15] |-> encoder1_position_word_b[POS_W-1:16] == '0 &&
      encoder1_position_word_b[15:0] inside {16'h0001, 16'h0004, 16'h0006, 16'h0007, 16'h0008};
  endproperty
  a_fault_code: assert property (p_fault_code) else $error("word b lacks fault code");

  property p_ack;
    $rose(encoder1_status_word[11]) |-> $past(telegram_valid) && $past(encoder1_control_word[15]) &&
      !encoder1_status_word[15];
  endproperty
  a_ack: assert property (p_ack) else $error("ack shown without request");

  property p_count;
    direct_access_en ##1 direct_access_en && enc1_step && enc1_dir && !encoder1_status_word[14]
      |=> encoder1_position_word_a == $past(encoder1_position_word_a) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("position did not count up");
endmodule : ecsw_chk

//--- bench/ecsw_ctrl_model.sv
// Controller model: sends both control words as one-cycle telegrams.
// Assumes the bench calls send from a single process.
`timescale 1ns/1ps
module ecsw_ctrl_model (
  input wire logic clk,
  output logic telegram_valid,
  output logic [ecsw_pkg::ECSW_WORD_W-1:0] cw1,
  output logic [ecsw_pkg::ECSW_WORD_W-1:0] cw2
);
  import ecsw_pkg::*;
  initial begin
    telegram_valid = 1'b0;
    cw1 = 16'h0000;
    cw2 = 16'h0000;
  end
  task automatic send(input logic [15:0] w1, input logic [15:0] w2);
    @(posedge clk);
    #1;
    telegram_valid = 1'b1;
    cw1 = w1 & ~ECSW_CW_RESERVED_MASK;
    cw2 = w2 & ~ECSW_CW_RESERVED_MASK;
    @(posedge clk);
    #1;
    telegram_valid = 1'b0;
    // Words flip outside telegrams so a stray sample is visible
    cw1 = ~cw1;
    cw2 = ~cw2;
  endtask : send
endmodule : ecsw_ctrl_model

//--- bench/ecsw_top_tb.sv
// Self-checking bench for the encoder word block.
// Assumes the controller model sends telegrams; the bench drives the encoder side.
`timescale 1ns/1ps
module ecsw_top_tb;
  import ecsw_pkg::*;
  logic clk, rst_n, direct_access_en, telegram_valid;
  logic [15:0] encoder1_control_word, encoder2_control_word, encoder1_status_word, encoder2_status_word;
  logic enc1_cam1_level, enc1_cam2_level, enc2_cam1_level, enc2_cam2_level;
  logic enc1_step, enc1_dir, enc2_step, enc2_dir, enc1_fault, enc2_fault;
  logic enc1_abs_valid, enc2_abs_valid, enc1_power_en, enc2_power_en;
  logic [31:0] enc1_abs_value, enc2_abs_value, encoder1_position_word_a, encoder2_position_word_a;
  logic [31:0] encoder1_position_word_b, encoder2_position_word_b;
  int errors = 0;
  int checks = 0;

  ecsw_top #(.POS_W(32)) i_dut (.clk, .rst_n, .direct_access_en, .telegram_valid,
    .encoder1_control_word, .encoder2_control_word, .enc1_cam1_level, .enc1_cam2_level,
    .enc2_cam1_level, .enc2_cam2_level, .enc1_step, .enc1_dir, .enc2_step, .enc2_dir,
    .enc1_fault, .enc2_fault, .enc1_abs_valid, .enc2_abs_valid, .enc1_abs_value, .enc2_abs_value,
    .encoder1_status_word, .encoder2_status_word, .encoder1_position_word_a, .encoder2_position_word_a,
    .encoder1_position_word_b, .encoder2_position_word_b, .enc1_power_en, .enc2_power_en);
  ecsw_ctrl_model i_ctl (.clk, .telegram_valid, .cw1(encoder1_control_word), .cw2(encoder2_control_word));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up;
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tg(input logic [15:0] w1, input logic [15:0] w2);
    i_ctl.send(w1, w2);
    cyc(1);
  endtask : tg

  // Bounded wait; referencing completion has no fixed latency at the ports
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    while (encoder1_status_word[b] !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    if (n == 8) begin
      errors++;
      $display("BAD %0t status bit %0d never set", $time, b);
    end
  endtask : wait_bit

  task automatic t_count;
    chk(encoder1_position_word_a, 32'h0000_0000);
    chk(encoder2_position_word_a, 32'h0000_0000);
    chk(enc1_power_en, 1'b1);
    enc1_step = 1'b1;
    enc2_step = 1'b1;
    enc2_dir = 1'b1;
    cyc(1);
    enc1_step = 1'b0;
    enc2_step = 1'b0;
    cyc(2);
    chk(encoder1_position_word_a, 32'hFFFF_FFFF);
    chk(encoder2_position_word_a, 32'h0000_0001);
    enc1_dir = 1'b1;
    repeat (4) begin
      enc1_step = 1'b1;
      cyc(1);
      enc1_step = 1'b0;
      cyc(1);
    end
    cyc(1);
    chk(encoder1_position_word_a, 32'h0000_0003);
  endtask : t_count

  task automatic t_search;
    tg(16'h0011, 16'h0000);
    chk(encoder1_status_word, 16'h0001);
    enc1_cam1_level = 1'b1;
    wait_bit(4);
    chk(encoder1_status_word, 16'h0110);
    tg(16'h0031, 16'h0000);
    chk(encoder1_position_word_b, 32'h0000_0003);
    tg(16'h0000, 16'h0000);
  endtask : t_search

  task automatic t_fly;
    tg(16'h0092, 16'h0000);
    chk(encoder1_status_word, 16'h0102);
    enc1_cam1_level = 1'b0;
    wait_bit(5);
    chk(encoder1_status_word, 16'h0020);
    tg(16'h0000, 16'h0000);
  endtask : t_fly

  task automatic t_fault;
    enc1_fault = 1'b1;
    cyc(2);
    chk(encoder1_status_word, 16'h8000);
    chk(encoder1_position_word_b, 32'h0000_0001);
    tg(16'h8000, 16'h0000);
    chk(encoder1_status_word, 16'h8000);
    enc1_fault = 1'b0;
    tg(16'h8000, 16'h0000);
    chk(encoder1_status_word, 16'h8000);
    tg(16'h0000, 16'h0000);
    tg(16'h8000, 16'h0000);
    chk(encoder1_status_word, 16'h0800);
    tg(16'h0000, 16'h0000);
    chk(encoder1_status_word, 16'h0000);
  endtask : t_fault

  // Refused requests: bad function pattern in each mode, read of an empty slot
  task automatic t_cancel;
    tg(16'h0013, 16'h0093);
    chk(encoder1_position_word_b, 32'h0000_0004);
    chk(encoder2_position_word_b, 32'h0000_0006);
    chk(encoder2_status_word, 16'h8000);
    tg(16'h8000, 16'h8000);
    chk(encoder1_status_word, 16'h0800);
    tg(16'h0028, 16'h0000);
    chk(encoder1_position_word_b, 32'h0000_0007);
    tg(16'h8000, 16'h0000);
    tg(16'h0000, 16'h0000);
    chk(encoder1_status_word, 16'h0000);
  endtask : t_cancel

  task automatic t_abs;
    enc1_abs_valid = 1'b1;
    enc1_abs_value = 32'h1234_5678;
    tg(16'h2000, 16'h2000);
    chk(encoder1_status_word, 16'h2000);
    chk(encoder1_position_word_b, 32'h1234_5678);
    chk(encoder2_status_word, 16'h8000);
    chk(encoder2_position_word_b, 32'h0000_0008);
    tg(16'h0000, 16'h8000);
    chk(encoder2_status_word, 16'h0800);
    tg(16'h0000, 16'h0000);
  endtask : t_abs

  task automatic t_access;
    enc2_cam2_level = 1'b1;
    cyc(2);
    chk(encoder2_status_word, 16'h0200);
    direct_access_en = 1'b0;
    cyc(2);
    chk(encoder2_status_word, 16'h0000);
    chk(encoder1_position_word_a, 32'h0000_0000);
    chk(encoder2_position_word_a, 32'h0000_0000);
    direct_access_en = 1'b1;
    enc2_cam2_level = 1'b0;
    cyc(2);
  endtask : t_access

  task automatic t_park;
    tg(16'h4000, 16'h4000);
    chk(encoder1_status_word, 16'h4000);
    chk(enc1_power_en, 1'b0);
    chk(encoder2_status_word, 16'h4000);
    chk(enc2_power_en, 1'b0);
    enc1_fault = 1'b1;
    cyc(2);
    chk(encoder1_status_word, 16'h4000);
    enc1_fault = 1'b0;
    tg(16'h0000, 16'h0000);
    chk(enc1_power_en, 1'b1);
    chk(enc2_power_en, 1'b1);
  endtask : t_park

  initial begin
    {rst_n, direct_access_en, enc1_cam1_level, enc1_cam2_level, enc2_cam1_level, enc2_cam2_level} = '0;
    {enc1_step, enc1_dir, enc2_step, enc2_dir, enc1_fault, enc2_fault, enc1_abs_valid, enc2_abs_valid} = '0;
    enc1_abs_value = 32'h0000_0000;
    enc2_abs_value = 32'h0000_0000;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    direct_access_en = 1'b1;
    t_count;
    t_search;
    t_fly;
    t_fault;
    t_cancel;
    t_abs;
    t_access;
    t_park;
    wrap_up;
  end

  // Whole run is under a hundred cycles
  initial begin
    #40000;
    errors++;
    wrap_up;
  end
endmodule : ecsw_top_tb

bind ecsw_top ecsw_chk #(.POS_W(POS_W)) i_chk (.clk, .rst_n, .direct_access_en, .telegram_valid,
  .encoder1_control_word, .enc1_cam1_level, .enc1_step, .enc1_dir, .enc1_fault,
  .encoder1_status_word, .encoder2_status_word, .encoder1_position_word_a,
  .encoder1_position_word_b, .enc1_power_en);

//--- hdl/ecsw_pkg.sv
// Constants for the encoder control and status word block.
// Assumes one 125 MHz clock; words are 16 bits, as carried in the cyclic telegram.
package ecsw_pkg;

  localparam int ECSW_NUM_ENC = 2;
  localparam int ECSW_WORD_W = 16;
  localparam int ECSW_POS_W = 32;
  localparam int ECSW_NUM_FUNC = 4;

  // Control word fields
  localparam int ECSW_CW_FUNC_LSB = 0;
  localparam int ECSW_CW_ACTIVATE = 4;
  localparam int ECSW_CW_READ = 5;
  localparam int ECSW_CW_MODE = 7;
  localparam int ECSW_CW_ABS = 13;
  localparam int ECSW_CW_PARK = 14;
  localparam int ECSW_CW_ACK = 15;
  localparam logic [15:0] ECSW_CW_RESERVED_MASK = 16'h1F40;
  localparam logic [15:0] ECSW_CW_RESET = 16'h0000;

  // Status word fields
  localparam int ECSW_SW_ACTIVE_LSB = 0;
  localparam int ECSW_SW_DONE_LSB = 4;
  localparam int ECSW_SW_CAM1 = 8;
  localparam int ECSW_SW_CAM2 = 9;
  localparam int ECSW_SW_ACKED = 11;
  localparam int ECSW_SW_ABS = 13;
  localparam int ECSW_SW_PARKED = 14;
  localparam int ECSW_SW_FAULT = 15;
  localparam logic [15:0] ECSW_SW_RESET = 16'h0000;
  localparam logic [31:0] ECSW_POS_RESET = 32'h0000_0000;

  // Fault codes carried in position word b while the fault bit is set
  localparam logic [15:0] ECSW_FC_ENCODER = 16'h0001;
  localparam logic [15:0] ECSW_FC_SEARCH_CANCEL = 16'h0004;
  localparam logic [15:0] ECSW_FC_FLY_CANCEL = 16'h0006;
  localparam logic [15:0] ECSW_FC_MEAS_CANCEL = 16'h0007;
  localparam logic [15:0] ECSW_FC_ABS_CANCEL = 16'h0008;

  typedef enum logic [3:0] {
    ECSW_ST_IDLE = 4'b0001,
    ECSW_ST_SEARCH = 4'b0010,
    ECSW_ST_FLY = 4'b0100,
    ECSW_ST_DONE = 4'b1000
  } ecsw_ref_state_t;

  function automatic logic ecsw_onehot4(input logic [3:0] f);
    ecsw_onehot4 = (f == 4'h1) || (f == 4'h2) || (f == 4'h4) || (f == 4'h8);
  endfunction : ecsw_onehot4

  function automatic logic [1:0] ecsw_func_idx(input logic [3:0] f);
    ecsw_func_idx = f[3] ? 2'd3 : f[2] ? 2'd2 : f[1] ? 2'd1 : 2'd0;
  endfunction : ecsw_func_idx

endpackage : ecsw_pkg

//--- hdl/ecsw_top.sv
// Encoder control and status word handling for two encoders.
// Assumes control words arrive with a one-cycle telegram_valid strobe, all inputs synchronous to clk.
`timescale 1ns/1ps
module ecsw_top #(
  parameter int POS_W = ecsw_pkg::ECSW_POS_W
) (
  input logic clk,
  input logic rst_n,
  input logic direct_access_en,
  input logic telegram_valid,
  input logic [ecsw_pkg::ECSW_WORD_W-1:0] encoder1_control_word,
  input logic [ecsw_pkg::ECSW_WORD_W-1:0] encoder2_control_word,
  input logic enc1_cam1_level,
  input logic enc1_cam2_level,
  input logic enc2_cam1_level,
  input logic enc2_cam2_level,
  input logic enc1_step,
  input logic enc1_dir,
  input logic enc2_step,
  input logic enc2_dir,
  input logic enc1_fault,
  input logic enc2_fault,
  input logic enc1_abs_valid,
  input logic enc2_abs_valid,
  input logic [POS_W-1:0] enc1_abs_value,
  input logic [POS_W-1:0] enc2_abs_value,
  output logic [ecsw_pkg::ECSW_WORD_W-1:0] encoder1_status_word,
  output logic [ecsw_pkg::ECSW_WORD_W-1:0] encoder2_status_word,
  output logic [POS_W-1:0] encoder1_position_word_a,
  output logic [POS_W-1:0] encoder2_position_word_a,
  output logic [POS_W-1:0] encoder1_position_word_b,
  output logic [POS_W-1:0] encoder2_position_word_b,
  output logic enc1_power_en,
  output logic enc2_power_en
);
  import ecsw_pkg::*;

  logic [ECSW_WORD_W-1:0] cw_in [ECSW_NUM_ENC];
  logic [1:0] cam_in [ECSW_NUM_ENC];
  logic step_in [ECSW_NUM_ENC];
  logic dir_in [ECSW_NUM_ENC];
  logic fault_in [ECSW_NUM_ENC];
  logic abs_vld_in [ECSW_NUM_ENC];
  logic [POS_W-1:0] abs_in [ECSW_NUM_ENC];
  logic [ECSW_WORD_W-1:0] sw_q [ECSW_NUM_ENC];
  logic [POS_W-1:0] wa_q [ECSW_NUM_ENC];
  logic [POS_W-1:0] wb_q [ECSW_NUM_ENC];
  logic pwr_q [ECSW_NUM_ENC];

  assign cw_in[0] = encoder1_control_word;
  assign cw_in[1] = encoder2_control_word;
  assign cam_in[0] = {enc1_cam2_level, enc1_cam1_level};
  assign cam_in[1] = {enc2_cam2_level, enc2_cam1_level};
  assign step_in[0] = enc1_step;
  assign step_in[1] = enc2_step;
  assign dir_in[0] = enc1_dir;
  assign dir_in[1] = enc2_dir;
  assign fault_in[0] = enc1_fault;
  assign fault_in[1] = enc2_fault;
  assign abs_vld_in[0] = enc1_abs_valid;
  assign abs_vld_in[1] = enc2_abs_valid;
  assign abs_in[0] = enc1_abs_value;
  assign abs_in[1] = enc2_abs_value;

  assign encoder1_status_word = sw_q[0];
  assign encoder2_status_word = sw_q[1];
  assign encoder1_position_word_a = wa_q[0];
  assign encoder2_position_word_a = wa_q[1];
  assign encoder1_position_word_b = wb_q[0];
  assign encoder2_position_word_b = wb_q[1];
  assign enc1_power_en = pwr_q[0];
  assign enc2_power_en = pwr_q[1];

  genvar g;
  generate
    for (g = 0; g < ECSW_NUM_ENC; g++) begin : g_enc
      logic [15:0] ctl;
      logic [15:0] next_ctl;
      ecsw_ref_state_t st;
      ecsw_ref_state_t next_st;
      logic [3:0] func;
      logic [3:0] next_func;
      logic run_fly;
      logic next_run_fly;
      logic [POS_W-1:0] pos;
      logic [POS_W-1:0] next_pos;
      logic [POS_W-1:0] refval [ECSW_NUM_FUNC];
      logic [POS_W-1:0] next_refval [ECSW_NUM_FUNC];
      logic [3:0] refvld;
      logic [3:0] next_refvld;
      logic [1:0] cam_prev;
      logic fault;
      logic next_fault;
      logic [15:0] fcode;
      logic [15:0] next_fcode;
      logic acked;
      logic next_acked;
      logic [15:0] next_sw;
      logic [POS_W-1:0] next_wa;
      logic [POS_W-1:0] next_wb;
      logic next_pwr;

      always_comb begin
        logic tlg;
        logic [15:0] cw;
        logic act_rise;
        logic read_rise;
        logic ack_rise;
        logic abs_rise;
        logic parked;
        logic onehot;
        logic [1:0] idx;
        logic [1:0] cam_rise;
        logic [1:0] cam_fall;
        logic hit;
        logic ev;
        logic [15:0] ev_code;
        logic ext_fault;
        logic abs_ok;
        logic [3:0] done_bits;
        tlg = telegram_valid & direct_access_en;
        cw = tlg ? (cw_in[g] & ~ECSW_CW_RESERVED_MASK) : ctl;
        act_rise = tlg & cw[ECSW_CW_ACTIVATE] & ~ctl[ECSW_CW_ACTIVATE];
        read_rise = tlg & cw[ECSW_CW_READ] & ~ctl[ECSW_CW_READ];
        ack_rise = tlg & cw[ECSW_CW_ACK] & ~ctl[ECSW_CW_ACK];
        abs_rise = tlg & cw[ECSW_CW_ABS] & ~ctl[ECSW_CW_ABS];
        parked = cw[ECSW_CW_PARK];
        onehot = ecsw_onehot4(cw[3:0]);
        idx = ecsw_func_idx(func);
        hit = 1'b0;
        cam_rise = cam_in[g] & ~cam_prev;
        cam_fall = ~cam_in[g] & cam_prev;
        ev = 1'b0;
        ev_code = ECSW_FC_ENCODER;
        // A parked encoder is switched off, so its own fault line means nothing
        ext_fault = fault_in[g] & ~parked;

        next_ctl = direct_access_en ? cw : ECSW_CW_RESET;
        next_st = st;
        next_func = func;
        next_run_fly = run_fly;
        next_refvld = refvld;
        for (int i = 0; i < ECSW_NUM_FUNC; i++) begin
          next_refval[i] = refval[i];
        end
        next_pos = pos;
        if (step_in[g]) begin
          next_pos = dir_in[g] ? pos + POS_W'(1) : pos - POS_W'(1);
        end

        case (st)
          ECSW_ST_IDLE: begin
            if (act_rise && !fault && !parked) begin
              if (!onehot) begin
                ev = 1'b1;
                ev_code = cw[ECSW_CW_MODE] ? ECSW_FC_FLY_CANCEL : ECSW_FC_SEARCH_CANCEL;
              end else begin
                next_func = cw[3:0];
                next_run_fly = cw[ECSW_CW_MODE];
                next_st = cw[ECSW_CW_MODE] ? ECSW_ST_FLY : ECSW_ST_SEARCH;
              end
            end
          end
          ECSW_ST_SEARCH: begin
            hit = (func[2] | func[3]) ? cam_in[g][1] : cam_in[g][0];
            if (!cw[ECSW_CW_ACTIVATE]) begin
              next_st = ECSW_ST_IDLE;
            end else if (cw[ECSW_CW_MODE] || read_rise) begin
              ev = 1'b1;
              ev_code = ECSW_FC_SEARCH_CANCEL;
              next_st = ECSW_ST_IDLE;
            end else if (hit) begin
              next_refval[idx] = pos;
              next_refvld[idx] = 1'b1;
              next_st = ECSW_ST_DONE;
            end
          end
          ECSW_ST_FLY: begin
            case (idx)
              2'd0: hit = cam_rise[0];
              2'd1: hit = cam_fall[0];
              2'd2: hit = cam_rise[1];
              default: hit = cam_fall[1];
            endcase
            if (!cw[ECSW_CW_ACTIVATE]) begin
              next_st = ECSW_ST_IDLE;
            end else if (!cw[ECSW_CW_MODE] || read_rise) begin
              ev = 1'b1;
              ev_code = ECSW_FC_FLY_CANCEL;
              next_st = ECSW_ST_IDLE;
            end else if (hit) begin
              next_refval[idx] = pos;
              next_refvld[idx] = 1'b1;
              next_st = ECSW_ST_DONE;
            end
          end
          ECSW_ST_DONE: begin
            if (!cw[ECSW_CW_ACTIVATE] || (cw[ECSW_CW_MODE] != run_fly)) begin
              next_st = ECSW_ST_IDLE;
            end
          end
          default: begin
            next_st = ECSW_ST_IDLE;
          end
        endcase

        // Reads outside referencing: one value, encoder powered, value captured
        if (read_rise && (st == ECSW_ST_IDLE || st == ECSW_ST_DONE)) begin
          if (!onehot || parked || !refvld[ecsw_func_idx(cw[3:0])]) begin
            ev = 1'b1;
            ev_code = ECSW_FC_MEAS_CANCEL;
          end
        end
        if (abs_rise && !abs_vld_in[g]) begin
          ev = 1'b1;
          ev_code = ECSW_FC_ABS_CANCEL;
        end
        if (fault || parked || !direct_access_en) begin
          next_st = ECSW_ST_IDLE;
        end

        next_fault = fault;
        next_fcode = fcode;
        next_acked = acked & cw[ECSW_CW_ACK];
        if (ack_rise && fault && !ext_fault) begin
          next_fault = 1'b0;
          next_acked = 1'b1;
        end
        // New fault in the acknowledge cycle keeps the fault set
        if (ev || ext_fault) begin
          next_fault = 1'b1;
          next_fcode = ev ? ev_code : ECSW_FC_ENCODER;
          next_acked = 1'b0;
        end
        if (!direct_access_en) begin
          next_acked = 1'b0;
        end

        abs_ok = cw[ECSW_CW_ABS] & abs_vld_in[g] & ~next_fault & ~parked;
        next_pwr = ~parked;

        if (next_run_fly) begin
          done_bits = (next_st == ECSW_ST_DONE) ? next_func : 4'h0;
        end else begin
          done_bits = (next_st == ECSW_ST_DONE) ?
            (next_func & {cam_in[g][1], cam_in[g][1], cam_in[g][0], cam_in[g][0]}) : 4'h0;
        end
        next_sw = ECSW_SW_RESET;
        if (next_st == ECSW_ST_SEARCH || next_st == ECSW_ST_FLY) begin
          next_sw[ECSW_SW_ACTIVE_LSB +: 4] = next_func;
        end
        next_sw[ECSW_SW_DONE_LSB +: 4] = done_bits;
        next_sw[ECSW_SW_CAM1] = cam_in[g][0];
        next_sw[ECSW_SW_CAM2] = cam_in[g][1];
        next_sw[ECSW_SW_ACKED] = next_acked;
        next_sw[ECSW_SW_ABS] = abs_ok;
        next_sw[ECSW_SW_PARKED] = parked;
        next_sw[ECSW_SW_FAULT] = next_fault;

        if (next_fault) begin
          next_wb = POS_W'(next_fcode);
        end else if (abs_ok) begin
          next_wb = abs_in[g];
        end else if (cw[ECSW_CW_READ] && onehot && !parked && next_refvld[ecsw_func_idx(cw[3:0])]) begin
          next_wb = next_refval[ecsw_func_idx(cw[3:0])];
        end else begin
          next_wb = ECSW_POS_RESET[POS_W-1:0];
        end
        next_wa = next_pos;

        // No direct access: both words and status hold zero
        if (!direct_access_en) begin
          next_sw = ECSW_SW_RESET;
          next_wb = ECSW_POS_RESET[POS_W-1:0];
          next_wa = ECSW_POS_RESET[POS_W-1:0];
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ctl <= ECSW_CW_RESET;
          st <= ECSW_ST_IDLE;
          func <= 4'h0;
          run_fly <= 1'b0;
          pos <= ECSW_POS_RESET[POS_W-1:0];
          for (int i = 0; i < ECSW_NUM_FUNC; i++) begin
            refval[i] <= ECSW_POS_RESET[POS_W-1:0];
          end
          refvld <= 4'h0;
          cam_prev <= 2'b00;
          fault <= 1'b0;
          fcode <= 16'h0000;
          acked <= 1'b0;
          sw_q[g] <= ECSW_SW_RESET;
          wa_q[g] <= ECSW_POS_RESET[POS_W-1:0];
          wb_q[g] <= ECSW_POS_RESET[POS_W-1:0];
          pwr_q[g] <= 1'b1;
        end else begin
          ctl <= next_ctl;
          st <= next_st;
          func <= next_func;
          run_fly <= next_run_fly;
          pos <= next_pos;
          for (int i = 0; i < ECSW_NUM_FUNC; i++) begin
            refval[i] <= next_refval[i];
          end
          refvld <= next_refvld;
          cam_prev <= cam_in[g];
          fault <= next_fault;
          fcode <= next_fcode;
          acked <= next_acked;
          sw_q[g] <= next_sw;
          wa_q[g] <= next_wa;
          wb_q[g] <= next_wb;
          pwr_q[g] <= next_pwr;
        end
      end
    end
  endgenerate

endmodule : ecsw_top
